// ### core/cgtc_csr_bank.sv
`default_nettype none
// Operation
// - override bit 0 lets gating run, 1 forces gating off; resets 0
// - bit 8 overrides gating of miscellaneous core logic
// - bit 7 decode unit, bit 6 execution unit overrides, reset 0
// - bit 5 fetch unit, bit 4 load/store unit overrides
// - bit 3 bus logic, bit 2 interrupt controller overrides, reset 0
// - bit 1 data memory, bit 0 instruction memory overrides
// - reserved bits read zero, writes to them ignored
// - writable registers accept any value and read back only legal values
// - enable bit 30 for correctable-error interrupt, reset 0
// - enable bits 11 external and 7 timer, reset 0
// - enable bit 3 stored but without effect
// - pending bits 30, 11, 7 are read-only, reset 0
// - no supervisor or user bits in enable or pending
// - exceptions record codes 1 to 7, machine ecall records 0xB
// - interrupts record bit 31 plus cause code
// - non-maskable traps record 0, 0xF0000000 or 0xF0000001
// - cause register holds only legal values; software writes legal ones
// - other cause values are reserved, never produced
module cgtc_csr_bank
  import cgtc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // csr access from the instruction pipeline
  input  wire cgtc_csr_req_t         csr_req,
  output logic                       csr_ack_r,
  output logic                       csr_err_r,
  output logic        [31:0]         csr_rdata_r,
  // hardware trap report
  input  wire cgtc_trap_t            trap_evt,
  // interrupt sources, asynchronous
  input  wire logic                  irq_ext_in,
  input  wire logic                  irq_timer_in,
  input  wire logic                  irq_ce_in,
  // unit activity, core clock
  input  wire logic  [GATE_W-1:0]    unit_busy_in,
  // gating, interrupt and trap cause outputs
  output logic       [GATE_W-1:0]    gate_override_r,
  output logic       [GATE_W-1:0]    unit_clk_en_r,
  output logic                       irq_ext_req_r,
  output logic                       irq_timer_req_r,
  output logic                       irq_ce_req_r,
  output logic        [31:0]         trap_cause_r
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic        hit_gate;
  logic        hit_en;
  logic        hit_pend;
  logic        hit_trap;
  logic        hit_any;
  logic        access;
  logic [31:0] irq_en_r;
  logic [31:0] irq_pend_r;
  logic [31:0] trap_nxt;
  logic        trap_wr_legal;
  logic [31:0] rdata_nxt;

  assign hit_gate = csr_req.addr == ADDR_GATE;
  assign hit_en   = csr_req.addr == ADDR_IRQ_EN;
  assign hit_pend = csr_req.addr == ADDR_IRQ_PEND;
  assign hit_trap = csr_req.addr == ADDR_TRAP;
  assign hit_any  = hit_gate | hit_en | hit_pend | hit_trap;
  assign access   = csr_req.rd | csr_req.wr;

  // ****************************************************************
  // gate override register
  // ****************************************************************
  // reset clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_override_r <= GATE_RST[GATE_W-1:0];
    end else if (csr_req.wr && hit_gate) begin
      gate_override_r <= csr_req.wdata[GATE_W-1:0];
    end
  end

  // forced clock enable
  // enable lags the override by one cycle; the gating cell latches it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_clk_en_r <= '0;
    end else begin
      unit_clk_en_r <= gate_override_r | unit_busy_in;
    end
  end

  // ****************************************************************
  // interrupt enable register
  // ****************************************************************
  // enable bits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r <= IRQ_EN_RST;
    end else if (csr_req.wr && hit_en) begin
      irq_en_r <= csr_req.wdata & IRQ_EN_MASK;
    end
  end

  // ****************************************************************
  // interrupt pending register
  // ****************************************************************
  // sources come from other domains; first stage feeds only the second
  logic [2:0] src_meta_r;
  logic [2:0] src_sync_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_meta_r <= '0;
      src_sync_r <= '0;
    end else begin
      src_meta_r <= {irq_ce_in, irq_ext_in, irq_timer_in};
      src_sync_r <= src_meta_r;
    end
  end

  // read-only pending, writes ignored
  // pending is a level: it follows the source, software cannot clear it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pend_r <= IRQ_PEND_RST;
    end else begin
      irq_pend_r                <= '0;
      irq_pend_r[IRQ_TIMER_BIT] <= src_sync_r[0];
      irq_pend_r[IRQ_EXT_BIT]   <= src_sync_r[1];
      irq_pend_r[IRQ_CE_BIT]    <= src_sync_r[2];
    end
  end

  // software enable ignored
  // no software request exists, so bit 3 never reaches a request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ext_req_r   <= 1'b0;
      irq_timer_req_r <= 1'b0;
      irq_ce_req_r    <= 1'b0;
    end else begin
      irq_ext_req_r   <= irq_pend_r[IRQ_EXT_BIT] & irq_en_r[IRQ_EXT_BIT];
      irq_timer_req_r <= irq_pend_r[IRQ_TIMER_BIT] & irq_en_r[IRQ_TIMER_BIT];
      irq_ce_req_r    <= irq_pend_r[IRQ_CE_BIT] & irq_en_r[IRQ_CE_BIT];
    end
  end

  // ****************************************************************
  // trap cause register
  // ****************************************************************
  cgtc_cause_filter u_filter (
    .cur_val  (trap_cause_r),
    .sw_val   (csr_req.wdata),
    .sw_wr    (csr_req.wr && hit_trap),
    .trap     (trap_evt),
    .nxt_val  (trap_nxt),
    .sw_legal (trap_wr_legal)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_cause_r <= TRAP_RST;
    end else begin
      trap_cause_r <= trap_nxt;
    end
  end

  // ****************************************************************
  // read and answer
  // ****************************************************************
  // reads show legal values
  always_comb begin
    rdata_nxt = '0;
    case (1'b1)
      hit_gate: rdata_nxt = {{(32-GATE_W){1'b0}}, gate_override_r};
      hit_en:   rdata_nxt = irq_en_r;
      hit_pend: rdata_nxt = irq_pend_r;
      hit_trap: rdata_nxt = trap_cause_r;
      default:  rdata_nxt = '0;
    endcase
  end

  // unmapped addresses answer with error and zero data
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      csr_ack_r   <= 1'b0;
      csr_err_r   <= 1'b0;
      csr_rdata_r <= '0;
    end else begin
      csr_ack_r   <= access;
      csr_err_r   <= access & ~hit_any;
      csr_rdata_r <= csr_req.rd ? rdata_nxt : '0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic [31:0] rd_addr_q;
  logic        rd_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_addr_q <= '0;
      rd_q      <= 1'b0;
    end else begin
      rd_addr_q <= {20'h0, csr_req.addr};
      rd_q      <= csr_req.rd;
    end
  end

  AST_GATE_WRITE: assert property (
    csr_req.wr && hit_gate |=> gate_override_r == $past(csr_req.wdata[GATE_W-1:0]))
    else $error("override write not stored");

  AST_GATE_RSVD: assert property (
    rd_q && rd_addr_q[11:0] == ADDR_GATE |-> csr_rdata_r[31:GATE_W] == '0)
    else $error("override reserved bits not zero");

  AST_CLK_FORCED: assert property (
    gate_override_r[GATE_DEC] && !(csr_req.wr && hit_gate)
      |=> unit_clk_en_r[GATE_DEC] [*2])
    else $error("forced clock enable dropped");

  AST_EN_MASKED: assert property (
    (irq_en_r & ~IRQ_EN_MASK) == '0 && (irq_pend_r & ~IRQ_PEND_MASK) == '0)
    else $error("unimplemented enable or pending bit set");

  AST_EN_WRITE: assert property (
    csr_req.wr && hit_en |=> irq_en_r[IRQ_EXT_BIT] == $past(csr_req.wdata[IRQ_EXT_BIT])
      && irq_en_r[IRQ_CE_BIT] == $past(csr_req.wdata[IRQ_CE_BIT]))
    else $error("enable write not stored");

  AST_PEND_TRACK: assert property (
    $stable(irq_timer_in) [*4] |-> irq_pend_r[IRQ_TIMER_BIT] == irq_timer_in)
    else $error("timer pending does not follow source");

  AST_TRAP_HW: assert property (
    trap_evt.take |=> trap_cause_r == cause_val($past(trap_evt.sel)))
    else $error("hardware trap cause wrong");

  AST_TRAP_LEGAL: assert property (
    cause_ok(trap_cause_r))
    else $error("cause register holds reserved value");

  AST_TRAP_DROP: assert property (
    csr_req.wr && hit_trap && !trap_wr_legal && !trap_evt.take |=> $stable(trap_cause_r))
    else $error("illegal cause write took effect");

  AST_ACK: assert property (
    access && !hit_any |=> csr_ack_r && csr_err_r && csr_rdata_r == '0)
    else $error("unmapped access answer wrong");

  COV_GATE_WR: cover property (csr_req.wr && hit_gate ##1 gate_override_r != '0);
  COV_NMI_LD: cover property (trap_evt.take && trap_evt.sel == SEL_NMI_LD);
  COV_BAD_WR: cover property (csr_req.wr && hit_trap && !trap_wr_legal);
  COV_IRQ: cover property (irq_ce_req_r);
  COV_CLK_FORCED: cover property (gate_override_r[GATE_MISC] && !unit_busy_in[GATE_MISC]);

  // ****************************************************************
  // override and clock enable checks
  // ****************************************************************

  AST_GATE_HOLD: assert property (
    !(csr_req.wr && hit_gate) |=> $stable(gate_override_r))
    else $error("override changed without a write");

  AST_GATE_RD: assert property (
    rd_q && rd_addr_q[11:0] == ADDR_GATE
      |-> csr_rdata_r == {{(32-GATE_W){1'b0}}, $past(gate_override_r)})
    else $error("override read data wrong");

  AST_CLK_ALL: assert property (
    gate_override_r != '0
      |=> (unit_clk_en_r & $past(gate_override_r)) == $past(gate_override_r))
    else $error("overridden unit lost its clock enable");

  AST_CLK_GATED: assert property (
    gate_override_r == '0 && unit_busy_in == '0 |=> unit_clk_en_r == '0)
    else $error("idle unit clock not gated");

  // ****************************************************************
  // interrupt checks
  // ****************************************************************

  AST_EN_TIMER: assert property (
    csr_req.wr && hit_en |=> irq_en_r[IRQ_TIMER_BIT] == $past(csr_req.wdata[IRQ_TIMER_BIT]))
    else $error("timer enable write not stored");

  AST_EN_SW: assert property (
    csr_req.wr && hit_en |=> irq_en_r[IRQ_SW_BIT] == $past(csr_req.wdata[IRQ_SW_BIT]))
    else $error("software enable write not stored");

  AST_EN_HOLD: assert property (
    !(csr_req.wr && hit_en) |=> $stable(irq_en_r))
    else $error("enable changed without a write");

  AST_PEND_EXT: assert property (
    $stable(irq_ext_in) [*4] |-> irq_pend_r[IRQ_EXT_BIT] == irq_ext_in)
    else $error("external pending does not follow source");

  AST_PEND_CE: assert property (
    $stable(irq_ce_in) [*4] |-> irq_pend_r[IRQ_CE_BIT] == irq_ce_in)
    else $error("correctable-error pending does not follow source");

  AST_REQ_MASK: assert property (
    !irq_en_r[IRQ_EXT_BIT] && !irq_en_r[IRQ_TIMER_BIT] |=> !irq_ext_req_r && !irq_timer_req_r)
    else $error("masked interrupt requested");

  AST_REQ_CE: assert property (
    irq_pend_r[IRQ_CE_BIT] && irq_en_r[IRQ_CE_BIT] |=> irq_ce_req_r)
    else $error("enabled correctable-error interrupt not requested");

  // ****************************************************************
  // cause and answer checks
  // ****************************************************************

  AST_TRAP_SW: assert property (
    csr_req.wr && hit_trap && trap_wr_legal && !trap_evt.take
      |=> trap_cause_r == $past(csr_req.wdata))
    else $error("legal cause write not stored");

  AST_TRAP_HOLD: assert property (
    !trap_evt.take && !(csr_req.wr && hit_trap) |=> $stable(trap_cause_r))
    else $error("cause changed without trap or write");

  AST_IDLE_QUIET: assert property (
    !access |=> !csr_ack_r && !csr_err_r && csr_rdata_r == '0)
    else $error("answer without a request");

  AST_MAPPED_OK: assert property (
    access && hit_any |=> csr_ack_r && !csr_err_r)
    else $error("mapped access answer wrong");

  AST_ERR_NOWRITE: assert property (
    csr_req.wr && !hit_any && !trap_evt.take
      |=> $stable(gate_override_r) && $stable(irq_en_r) && $stable(trap_cause_r))
    else $error("unmapped write changed a register");

endmodule
`default_nettype wire

// ### common/cgtc_pkg.sv
`default_nettype none
package cgtc_pkg;

  // ****************************************************************
  // register offsets in the control/status space
  // ****************************************************************
  localparam int          CSR_AW          = 12;
  localparam logic [11:0] ADDR_IRQ_EN     = 12'h304;
  localparam logic [11:0] ADDR_TRAP       = 12'h342;
  localparam logic [11:0] ADDR_IRQ_PEND   = 12'h344;
  localparam logic [11:0] ADDR_GATE       = 12'h7F8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int GATE_W         = 9;
  localparam int GATE_ICCM      = 0;
  localparam int GATE_DCCM      = 1;
  localparam int GATE_PIC       = 2;
  localparam int GATE_BUS       = 3;
  localparam int GATE_LSU       = 4;
  localparam int GATE_IFU       = 5;
  localparam int GATE_EXU       = 6;
  localparam int GATE_DEC       = 7;
  localparam int GATE_MISC      = 8;
  localparam int IRQ_SW_BIT     = 3;
  localparam int IRQ_TIMER_BIT  = 7;
  localparam int IRQ_EXT_BIT    = 11;
  localparam int IRQ_CE_BIT     = 30;

  // ****************************************************************
  // implemented-bit masks and reset values
  // ****************************************************************
  localparam logic [31:0] GATE_MASK     = 32'h0000_01FF;
  localparam logic [31:0] IRQ_EN_MASK   = 32'h4000_0888;
  localparam logic [31:0] IRQ_PEND_MASK = 32'h4000_0880;
  localparam logic [31:0] GATE_RST      = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RST    = 32'h0000_0000;
  localparam logic [31:0] IRQ_PEND_RST  = 32'h0000_0000;
  localparam logic [31:0] TRAP_RST      = 32'h0000_0000;

  // ****************************************************************
  // trap cause encodings
  // ****************************************************************
  localparam logic [31:0] CAUSE_NMI_PIN   = 32'h0000_0000;
  localparam logic [31:0] CAUSE_EXC_FIRST = 32'h0000_0001;
  localparam logic [31:0] CAUSE_EXC_LAST  = 32'h0000_0007;
  localparam logic [31:0] CAUSE_ECALL_M   = 32'h0000_000B;
  localparam logic [31:0] CAUSE_IRQ_TIMER = 32'h8000_0007;
  localparam logic [31:0] CAUSE_IRQ_EXT   = 32'h8000_000B;
  localparam logic [31:0] CAUSE_IRQ_CE    = 32'h8000_001E;
  localparam logic [31:0] CAUSE_NMI_ST    = 32'hF000_0000;
  localparam logic [31:0] CAUSE_NMI_LD    = 32'hF000_0001;

  typedef enum logic [3:0] {
    SEL_NMI_PIN  = 4'h0,
    SEL_IFETCH   = 4'h1,
    SEL_ILLEGAL  = 4'h2,
    SEL_BRKPT    = 4'h3,
    SEL_LD_MIS   = 4'h4,
    SEL_LD_FAULT = 4'h5,
    SEL_ST_MIS   = 4'h6,
    SEL_ST_FAULT = 4'h7,
    SEL_ECALL    = 4'h8,
    SEL_TIMER    = 4'h9,
    SEL_EXT      = 4'hA,
    SEL_CE       = 4'hB,
    SEL_NMI_ST   = 4'hC,
    SEL_NMI_LD   = 4'hD
  } cgtc_cause_sel_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cgtc_csr_req_t;

  typedef struct packed {
    logic            take;
    cgtc_cause_sel_t sel;
  } cgtc_trap_t;

  // map a hardware trap selector onto its cause value
  function automatic logic [31:0] cause_val(input cgtc_cause_sel_t sel);
    logic [31:0] v;
    v = CAUSE_NMI_PIN;
    case (sel)
      SEL_IFETCH, SEL_ILLEGAL, SEL_BRKPT, SEL_LD_MIS,
      SEL_LD_FAULT, SEL_ST_MIS, SEL_ST_FAULT: v = {28'h0, sel};
      SEL_ECALL:  v = CAUSE_ECALL_M;
      SEL_TIMER:  v = CAUSE_IRQ_TIMER;
      SEL_EXT:    v = CAUSE_IRQ_EXT;
      SEL_CE:     v = CAUSE_IRQ_CE;
      SEL_NMI_ST: v = CAUSE_NMI_ST;
      SEL_NMI_LD: v = CAUSE_NMI_LD;
      default:    v = CAUSE_NMI_PIN;
    endcase
    return v;
  endfunction

  function automatic logic cause_ok(input logic [31:0] v);
    return (v <= CAUSE_EXC_LAST) || (v == CAUSE_ECALL_M) ||
           (v == CAUSE_IRQ_TIMER) || (v == CAUSE_IRQ_EXT) ||
           (v == CAUSE_IRQ_CE) || (v == CAUSE_NMI_ST) || (v == CAUSE_NMI_LD);
  endfunction

endpackage
`default_nettype wire

// ### core/cgtc_cause_filter.sv
`default_nettype none
module cgtc_cause_filter
  import cgtc_pkg::*;
(
  // current and proposed values
  input  wire logic [31:0] cur_val,
  input  wire logic [31:0] sw_val,
  input  wire logic        sw_wr,
  input  wire cgtc_trap_t  trap,
  // next value
  output logic      [31:0] nxt_val,
  output logic             sw_legal
);

  // ****************************************************************
  // next cause value
  // ****************************************************************
  // hardware traps win over a software write in the same cycle;
  // an illegal software value is dropped so the register stays legal
  always_comb begin
    sw_legal = cause_ok(sw_val);
    nxt_val  = cur_val;
    if (trap.take) begin
      nxt_val = cause_val(trap.sel);
    end else if (sw_wr && sw_legal) begin
      nxt_val = sw_val;
    end
  end

endmodule
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
`define CHK(nm, ex, got) \
  begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb
  import cgtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic              ref_clk;
  logic              rst_b;
  cgtc_csr_req_t     csr_req;
  cgtc_trap_t        trap_evt;
  logic [2:0]        irq_src;
  logic [GATE_W-1:0] unit_busy_in;
  logic              csr_ack_r;
  logic              csr_err_r;
  logic [31:0]       csr_rdata_r;
  logic [GATE_W-1:0] gate_override_r;
  logic [GATE_W-1:0] unit_clk_en_r;
  wire  [2:0]        irq_req;
  logic [31:0]       trap_cause_r;
  int                fails = 0;
  int                n_compared = 0;

  cgtc_csr_bank DUT (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .csr_req         (csr_req),
    .csr_ack_r       (csr_ack_r),
    .csr_err_r       (csr_err_r),
    .csr_rdata_r     (csr_rdata_r),
    .trap_evt        (trap_evt),
    .irq_ext_in      (irq_src[0]),
    .irq_timer_in    (irq_src[1]),
    .irq_ce_in       (irq_src[2]),
    .unit_busy_in    (unit_busy_in),
    .gate_override_r (gate_override_r),
    .unit_clk_en_r   (unit_clk_en_r),
    .irq_ext_req_r   (irq_req[0]),
    .irq_timer_req_r (irq_req[1]),
    .irq_ce_req_r    (irq_req[2]),
    .trap_cause_r    (trap_cause_r)
  );

  always #50 ref_clk = ~ref_clk;

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // request held one cycle; ack is looked at only in the cycle it stands
  task automatic csr_op(input logic rd, input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    csr_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge ref_clk);
    csr_req <= '0;
    #1;
    `CHK("ack", 1'b1, csr_ack_r)
    r = csr_rdata_r;
    e = csr_err_r;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    csr_op(1'b0, 1'b1, a, d, r, e);
    `CHK($sformatf("wr err %h", a), 1'b0, e)
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    csr_op(1'b1, 1'b0, a, 32'h0, r, e);
    `CHK($sformatf("rd err %h", a), 1'b0, e)
    `CHK($sformatf("rdata %h", a), ex, r)
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_gate();
    wr(ADDR_GATE, 32'hFFFF_FFFF);
    rd_chk(ADDR_GATE, 32'h0000_01FF);
    for (int i = 0; i < GATE_W; i++) begin
      wr(ADDR_GATE, 32'h1 << i);
      rd_chk(ADDR_GATE, 32'h1 << i);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("override", 9'h001 << i, gate_override_r)
      `CHK("clk_en idle", 9'h001 << i, unit_clk_en_r)
    end
    wr(ADDR_GATE, 32'h0);
    @(posedge ref_clk);
    unit_busy_in <= 9'h155;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("clk_en busy", 9'h155, unit_clk_en_r)
    @(posedge ref_clk);
    unit_busy_in <= '0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("clk_en gated", 9'h000, unit_clk_en_r)
  endtask

  task automatic t_irq();
    logic [31:0] bit_of [3] = '{32'h0000_0800, 32'h0000_0080, 32'h4000_0000};
    wr(ADDR_IRQ_EN, 32'hFFFF_FFFF);
    rd_chk(ADDR_IRQ_EN, 32'h4000_0888);
    // only the stored software enable set: nothing may be requested
    wr(ADDR_IRQ_EN, 32'h0000_0008);
    rd_chk(ADDR_IRQ_EN, 32'h0000_0008);
    `CHK("sw no req", 3'b000, irq_req)
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_IRQ_EN, bit_of[i]);
      rd_chk(ADDR_IRQ_EN, bit_of[i]);
      @(posedge ref_clk);
      irq_src[i] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK("req", 3'b001 << i, irq_req)
      rd_chk(ADDR_IRQ_PEND, bit_of[i]);
      wr(ADDR_IRQ_PEND, 32'h0);
      rd_chk(ADDR_IRQ_PEND, bit_of[i]);
      wr(ADDR_IRQ_EN, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("masked", 3'b000, irq_req)
      @(posedge ref_clk);
      irq_src[i] <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rd_chk(ADDR_IRQ_PEND, 32'h0);
    end
  endtask

  task automatic t_trap();
    logic [31:0] ex [14] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7,
                             32'h0000_000B, 32'h8000_0007, 32'h8000_000B,
                             32'h8000_001E, 32'hF000_0000, 32'hF000_0001};
    for (int k = 13; k >= 0; k--) begin
      @(posedge ref_clk);
      trap_evt <= '{take: 1'b1, sel: cgtc_cause_sel_t'(4'(k))};
      @(posedge ref_clk);
      trap_evt <= '0;
      #1;
      `CHK($sformatf("cause %0d", k), ex[k], trap_cause_r)
    end
    rd_chk(ADDR_TRAP, 32'h0);
  endtask

  task automatic t_cause_sw();
    logic [31:0] bad [4] = '{32'h0000_0008, 32'h8000_0000, 32'hF000_0002, 32'h0000_000C};
    wr(ADDR_TRAP, 32'h8000_001E);
    rd_chk(ADDR_TRAP, 32'h8000_001E);
    foreach (bad[j]) begin
      wr(ADDR_TRAP, bad[j]);
      rd_chk(ADDR_TRAP, 32'h8000_001E);
    end
    // hardware report and software write collide in one cycle
    @(posedge ref_clk);
    csr_req <= '{rd: 1'b0, wr: 1'b1, addr: ADDR_TRAP, wdata: 32'h8000_000B};
    trap_evt <= '{take: 1'b1, sel: SEL_TIMER};
    @(posedge ref_clk);
    csr_req <= '0;
    trap_evt <= '0;
    #1;
    `CHK("trap wins", 32'h8000_0007, trap_cause_r)
  endtask

  task automatic t_b2b_unmapped();
    logic [31:0] r;
    logic        e;
    wr(ADDR_GATE, 32'h0000_0055);
    @(posedge ref_clk);
    csr_req <= '{rd: 1'b1, wr: 1'b0, addr: ADDR_GATE, wdata: 32'h0};
    @(posedge ref_clk);
    csr_req <= '{rd: 1'b1, wr: 1'b1, addr: 12'h7F9, wdata: 32'hFFFF_FFFF};
    #1;
    `CHK("b2b data", 32'h0000_0055, csr_rdata_r)
    @(posedge ref_clk);
    csr_req <= '0;
    #1;
    `CHK("unmapped ack", 1'b1, csr_ack_r)
    `CHK("unmapped err", 1'b1, csr_err_r)
    `CHK("unmapped data", 32'h0, csr_rdata_r)
    @(posedge ref_clk);
    #1;
    `CHK("ack falls", 1'b0, csr_ack_r)
    // read and write together: the write lands, the read shows the old value
    csr_op(1'b1, 1'b1, ADDR_GATE, 32'h0000_01AA, r, e);
    `CHK("rw old", 32'h0000_0055, r)
    rd_chk(ADDR_GATE, 32'h0000_01AA);
  endtask

  // second reset in mid-run must clear everything written so far
  task automatic t_rereset();
    wr(ADDR_GATE, 32'h0000_01FF);
    wr(ADDR_IRQ_EN, 32'h4000_0888);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("override in reset", 9'h000, gate_override_r)
    @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(ADDR_GATE, 32'h0);
    rd_chk(ADDR_IRQ_EN, 32'h0);
    rd_chk(ADDR_IRQ_PEND, 32'h0);
    rd_chk(ADDR_TRAP, 32'h0);
  endtask

  // ****************************************************************
  // verdict and run control
  // ****************************************************************
  task automatic final_report();
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is about 250 cycles; the limit of 6000 cycles lies far above it
  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    final_report();
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    csr_req = '0;
    trap_evt = '0;
    irq_src = '0;
    unit_busy_in = '0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(ADDR_GATE, 32'h0);
    t_gate();
    t_irq();
    t_trap();
    t_cause_sw();
    t_b2b_unmapped();
    t_rereset();
    final_report();
  end
endmodule
`default_nettype wire
